// ==== design/mil_irq.v ====
// Function
// (RQ1) Four sources: pin edge, timer overflow, port change, comparator.
// (RQ2) Global enable in control bit 7 gates all; every reset clears it.
// (RQ3) Return from handler sets the global enable again.
// (RQ4) Accepting clears global enable, pushes return address, loads 0004h.
// (RQ5) Flags set by events regardless of any enable bit.
// (RQ6) Pin edge and port change are serviced three or four cycles later.
// (RQ7) Clearing global enable forces one no-op; pending requests wait.
// (RQ8) Pin edge polarity from option bit 6; sets pin flag bit 1.
// (RQ9) Pin enable bit 4 clear disables the pin interrupt.
// (RQ10) Pin edge wakes from sleep if pin enable set; global decides branch.
// (RQ11) Timer rollover sets flag bit 2; timer enable bit 5 gates it.
// (RQ12) Change on upper port pins sets flag bit 0; port enable gates it.
// (RQ13) A change coinciding with a port read may not set the flag.
// (RQ14) Comparator flag and enable in bit 6; group enable gates it.
// (RQ15) Pin flag may be set during Q4 through Q1 phases.
// (RQ16) Only the return address is saved on entry.
// (RQ17) Handler software clears serviced flags before re-enabling.
// (RQ18) Any enabled source with flag set wakes from sleep.
// (RQ19) Woken with global enable set, run prefetched op then vector.
// (RQ20) Request is global enable and OR of flag-enable pairs.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mil_regs.vh"

module mil_irq #(
    parameter PORT_W = `MIL_PORT_W
) (
    input  wire                     clock,
    input  wire                     rst,
    input  wire [`MIL_ADDR_W-1:0]   addr,
    input  wire [7:0]               wdata,
    input  wire                     wr,
    input  wire                     rd,
    output reg  [7:0]               rdata,
    input  wire                     external_irq_pin,
    input  wire [PORT_W-1:0]        port_pins,
    input  wire                     port_read,
    input  wire                     timer_rollover,
    input  wire                     comparator_event,
    input  wire                     return_from_handler,
    input  wire                     sleeping,
    output reg                      irq_req,
    output reg                      wake_req,
    output reg                      force_nop,
    output reg                      push_return,
    output reg                      pc_load,
    output reg  [`MIL_VECTOR_W-1:0] vector_addr,
    output reg  [1:0]               q_phase
);

    // ==========================================================
    // State encoding, one-hot
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_NOP   = 3'h2;
    localparam [2:0] ST_ENTRY = 3'h4;

    // ==========================================================
    // Registers
    reg [7:0] ctrl_reg;
    reg [7:0] ctrl_next;
    reg       cmp_flag_reg;
    reg       cmp_flag_next;
    reg       cmp_en_reg;
    reg       edge_sel_reg;
    reg       pin_pend_reg;
    reg       gclr_reg;
    reg       hold_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;

    wire pin_edge;
    wire port_change;

    // ==========================================================
    // Source front ends
    mil_pin_edge u_pin (
        .clock      (clock),
        .rst        (rst),
        .pin        (external_irq_pin),
        .rising_sel (edge_sel_reg),
        .edge_seen  (pin_edge)
    );

    mil_port_watch #(
        .W (PORT_W)
    ) u_port (
        .clock     (clock),
        .rst       (rst),
        .pins      (port_pins),
        .port_read (port_read),
        .mismatch  (port_change)
    );

    // ==========================================================
    // Helpers
    function [7:0] byte_of_bit;
        input       val;
        input [2:0] pos;
        begin
            byte_of_bit = `MIL_RST_BYTE;
            byte_of_bit[pos] = val;
        end
    endfunction

    // Flag-and-enable pairs; the group gate applies to the comparator
    function any_pending;
        input [7:0] c;
        input       cf;
        input       ce;
        begin
            any_pending = (c[`MIL_BIT_TFLAG] & c[`MIL_BIT_TIE])
                        | (c[`MIL_BIT_PFLAG] & c[`MIL_BIT_PIE])    // [RQ9]
                        | (c[`MIL_BIT_PCFLAG] & c[`MIL_BIT_PCE])
                        | (cf & ce & c[`MIL_BIT_PERIPHERAL_GROUP_ENABLE]);            // [RQ14]
        end
    endfunction

    wire wr_ctrl = wr & (addr == `MIL_OFF_CTRL);
    wire wr_pfl  = wr & (addr == `MIL_OFF_PFLAGS);
    wire wr_pen  = wr & (addr == `MIL_OFF_PENABLES);
    wire wr_opt  = wr & (addr == `MIL_OFF_OPTION);
    wire phase_q4 = (q_phase == `MIL_Q4);
    // A pin edge may only set the pin flag in the Q4..Q1 window; a control write sets it in any phase
    wire pin_window = phase_q4 | (q_phase == `MIL_Q1);          // [RQ15]
    wire pend_any = any_pending(ctrl_reg, cmp_flag_reg, cmp_en_reg);
    // Software clearing the global enable opens a no-op window
    wire gie_sw_clear = wr_ctrl & ~wdata[`MIL_BIT_GIE]
                        & ctrl_reg[`MIL_BIT_GIE];                // [RQ7]
    wire accept = (state_reg == ST_IDLE) & phase_q4 & irq_req
                  & ~gclr_reg & ~hold_reg & ~wr_ctrl;            // [RQ7]

    // ==========================================================
    // Instruction phase counter
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            q_phase <= `MIL_Q1;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // ==========================================================
    // Control register next value; hardware set wins over a clear
    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = wdata;
        end
        if (timer_rollover) begin
            ctrl_next[`MIL_BIT_TFLAG] = 1'b1;                     // [RQ11]
        end
        if (pin_pend_reg & pin_window) begin
            ctrl_next[`MIL_BIT_PFLAG] = 1'b1;                     // [RQ8]
        end
        if (port_change) begin
            ctrl_next[`MIL_BIT_PCFLAG] = 1'b1;                    // [RQ12]
        end
        // Flags above ignore every enable bit [RQ5]
        if (accept) begin
            ctrl_next[`MIL_BIT_GIE] = 1'b0;                       // [RQ4]
        end
        if (return_from_handler) begin
            ctrl_next[`MIL_BIT_GIE] = 1'b1;                       // [RQ3]
        end
    end

    always @* begin
        cmp_flag_next = cmp_flag_reg;
        if (wr_pfl) begin
            cmp_flag_next = wdata[`MIL_BIT_CMP];
        end
        if (comparator_event) begin
            cmp_flag_next = 1'b1;                                 // [RQ14]
        end
    end

    // ==========================================================
    // Register file
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg     <= `MIL_RST_CTRL;                        // [RQ2]
            cmp_flag_reg <= `MIL_RST_PFLAGS;
            cmp_en_reg   <= `MIL_RST_PENABLES;
            edge_sel_reg <= `MIL_RST_EDGE;
            pin_pend_reg <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            cmp_flag_reg <= cmp_flag_next;
            if (wr_pen) begin
                cmp_en_reg <= wdata[`MIL_BIT_CMP];
            end
            if (wr_opt) begin
                edge_sel_reg <= wdata[`MIL_BIT_EDGE];
            end
            // Edge waits outside the window so it is never lost
            if (pin_edge & ~pin_window) begin
                pin_pend_reg <= 1'b1;
            end else if (pin_window) begin
                pin_pend_reg <= pin_edge;
            end
        end
    end

    // ==========================================================
    // Read port: data valid in the cycle after the strobe
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= `MIL_RST_BYTE;
        end else if (rd) begin
            case (addr)
                `MIL_OFF_CTRL:     rdata <= ctrl_reg;
                `MIL_OFF_PFLAGS:   rdata <= byte_of_bit(cmp_flag_reg,
                                                        `MIL_BIT_CMP);
                `MIL_OFF_PENABLES: rdata <= byte_of_bit(cmp_en_reg,
                                                        `MIL_BIT_CMP);
                `MIL_OFF_OPTION:   rdata <= byte_of_bit(edge_sel_reg,
                                                        `MIL_BIT_EDGE);
                default:           rdata <= `MIL_RST_BYTE;
            endcase
        end else begin
            rdata <= `MIL_RST_BYTE;
        end
    end

    // ==========================================================
    // No-op window after a global enable clear by software
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            gclr_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            if (gie_sw_clear) begin
                gclr_reg <= 1'b1;
            end else if (phase_q4) begin
                gclr_reg <= 1'b0;
            end
            if (phase_q4) begin
                hold_reg <= gclr_reg | (gie_sw_clear);            // [RQ7]
            end
        end
    end

    // ==========================================================
    // Entry sequencer: one no-op cycle, then push and vector load.
    // Pin flag lands in Q4/Q1, accept at a Q4, one dummy cycle, then
    // the vector: three or four instruction cycles in all.
    always @* begin
        case (state_reg)
            ST_IDLE:  state_next = accept ? ST_NOP : ST_IDLE;     // [RQ6]
            ST_NOP:   state_next = phase_q4 ? ST_ENTRY : ST_NOP;
            ST_ENTRY: state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            push_return <= 1'b0;
            pc_load     <= 1'b0;
            force_nop   <= 1'b0;
            vector_addr <= `MIL_VECTOR;
        end else begin
            state_reg <= state_next;
            // Only the return address is pushed; working state is
            // left to handler code [RQ16]
            push_return <= (state_next == ST_ENTRY);              // [RQ4]
            pc_load     <= (state_next == ST_ENTRY);              // [RQ4]
            vector_addr <= `MIL_VECTOR;
            force_nop   <= (state_next == ST_NOP) | hold_reg
                           | gclr_reg;                            // [RQ7]
        end
    end

    // ==========================================================
    // Request and wake outputs. Requests stay until handler code
    // clears the flags; a stale flag re-enters at once.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_req  <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq_req  <= ctrl_next[`MIL_BIT_GIE]
                        & any_pending(ctrl_next, cmp_flag_next,
                                      cmp_en_reg);                // [RQ20]
            // Wake ignores the global enable; after it the core runs
            // the prefetched op, and the vector follows only if the
            // global enable holds irq_req high [RQ19]
            wake_req <= sleeping & pend_any;                      // [RQ18]
        end
    end
    // Pin wake follows from its pair in pend_any [RQ10]
    // Four sources feed any_pending [RQ1]; flag clearing before
    // re-enable is left to handler code [RQ17]

endmodule

// ==== design/mil_pin_edge.v ====
`timescale 1ns/1ps

module mil_pin_edge (
    input  wire clock,
    input  wire rst,
    input  wire pin,
    input  wire rising_sel,
    output reg  edge_seen
);

    // ==========================================================
    // Two-stage synchroniser, then edge detection
    reg meta_reg;
    reg sync_reg;
    reg prev_reg;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            prev_reg  <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            meta_reg  <= pin;
            sync_reg  <= meta_reg;
            prev_reg  <= sync_reg;
            // Polarity picked by the edge select bit [RQ8]
            edge_seen <= rising_sel ? (sync_reg & ~prev_reg)
                                    : (~sync_reg & prev_reg);
        end
    end

endmodule

// ==== design/mil_port_watch.v ====
`timescale 1ns/1ps

module mil_port_watch #(
    parameter W = 4
) (
    input  wire         clock,
    input  wire         rst,
    input  wire [W-1:0] pins,
    input  wire         port_read,
    output reg          mismatch
);

    // ==========================================================
    // Synchroniser and read latch
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;
    reg [W-1:0] latch_reg;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg  <= {W{1'b0}};
            sync_reg  <= {W{1'b0}};
            latch_reg <= {W{1'b0}};
            mismatch  <= 1'b0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            // A read reloads the latch, so a change landing on the read
            // itself is absorbed and never flagged [RQ13]
            if (port_read) begin
                latch_reg <= sync_reg;
            end
            mismatch <= (sync_reg != latch_reg) & ~port_read; // [RQ12]
        end
    end

endmodule

// ==== design/mil_regs.vh ====
`ifndef MIL_REGS_VH
`define MIL_REGS_VH

// ==========================================================
// Register offsets
`define MIL_ADDR_W          8
`define MIL_OFF_CTRL        8'h0B
`define MIL_OFF_PFLAGS      8'h0C
`define MIL_OFF_OPTION      8'h81
`define MIL_OFF_PENABLES    8'h8C

// ==========================================================
// interrupt_control fields
`define MIL_BIT_GIE         7
`define MIL_BIT_PERIPHERAL_GROUP_ENABLE        6
`define MIL_BIT_TIE         5
`define MIL_BIT_PIE         4
`define MIL_BIT_PCE         3
`define MIL_BIT_TFLAG       2
`define MIL_BIT_PFLAG       1
`define MIL_BIT_PCFLAG      0

// ==========================================================
// Peripheral and option fields
`define MIL_BIT_CMP         3'h6
`define MIL_BIT_EDGE        3'h6

// ==========================================================
// Reset values
`define MIL_RST_CTRL        8'h00
`define MIL_RST_PFLAGS      1'b0
`define MIL_RST_PENABLES    1'b0
`define MIL_RST_EDGE        1'b1
`define MIL_RST_BYTE        8'h00

// ==========================================================
// Vector and instruction phases
`define MIL_VECTOR_W        13
`define MIL_VECTOR          13'h0004
`define MIL_Q1              2'h0
`define MIL_Q2              2'h1
`define MIL_Q3              2'h2
`define MIL_Q4              2'h3
`define MIL_PORT_W          4

`endif

// ==== verification/mil_cpu_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Core sequencer model: takes the vector, runs a fixed handler
module mil_cpu_model #(
    parameter HANDLER = 12
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        pc_load,
    input  wire [12:0] vector_addr,
    output reg         return_from_handler,
    output reg  [12:0] pc
);
    reg [7:0] cnt_reg;
    reg       busy_reg;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            return_from_handler <= 1'b0;
            pc <= 13'h0000;
        end else begin
            return_from_handler <= 1'b0;
            if (pc_load) begin
                // Only the vector is taken; no context is stacked
                pc <= vector_addr;
                busy_reg <= 1'b1;
                cnt_reg <= HANDLER;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    busy_reg <= 1'b0;
                    return_from_handler <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== verification/mil_irq_chk.sv ====
`timescale 1ns/1ps
`include "mil_regs.vh"
// ==========================================================
// Port checker
module mil_irq_chk #(
    parameter PORT_W = 4
) (
    input wire                     clock,
    input wire                     rst,
    input wire [`MIL_ADDR_W-1:0]   addr,
    input wire [7:0]               wdata,
    input wire                     wr,
    input wire                     rd,
    input wire [7:0]               rdata,
    input wire                     external_irq_pin,
    input wire [PORT_W-1:0]        port_pins,
    input wire                     port_read,
    input wire                     timer_rollover,
    input wire                     comparator_event,
    input wire                     return_from_handler,
    input wire                     sleeping,
    input wire                     irq_req,
    input wire                     wake_req,
    input wire                     force_nop,
    input wire                     push_return,
    input wire                     pc_load,
    input wire [`MIL_VECTOR_W-1:0] vector_addr,
    input wire [1:0]               q_phase
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_vec; vector_addr == `MIL_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_pair; push_return == pc_load; endproperty
    a_pair: assert property (p_pair) else $error("push/load split");
    property p_one; push_return |=> !push_return; endproperty
    a_one: assert property (p_one) else $error("push too long");
    property p_pushq; push_return |-> $past(q_phase) == `MIL_Q4; endproperty
    a_pushq: assert property (p_pushq) else $error("push off Q4");
    // The no-op window drops in the push cycle itself
    property p_nop;
        push_return |-> $past(force_nop) && $past(force_nop, 4);
    endproperty
    a_nop: assert property (p_nop) else $error("no nop before push");
    // Shortest no-op window is four cycles, on interrupt entry; the check needs all four
    property p_nlen; $rose(force_nop) |-> force_nop [*4]; endproperty
    a_nlen: assert property (p_nlen) else $error("nop too short");
    property p_wake; wake_req |-> $past(sleeping); endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    // The counter holds Q1 through the first edge after reset
    property p_ph;
        !$past(rst) |-> q_phase == $past(q_phase) + 2'h1;
    endproperty
    a_ph: assert property (p_ph) else $error("phase skipped");
    property p_rdz; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("stray read data");
    c_push: cover property (push_return);
    c_wake: cover property (wake_req);
    c_nop: cover property ($rose(force_nop));
endmodule

bind mil_irq mil_irq_chk #(.PORT_W(PORT_W)) u_chk (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .external_irq_pin(external_irq_pin),
    .port_pins(port_pins), .port_read(port_read),
    .timer_rollover(timer_rollover), .comparator_event(comparator_event),
    .return_from_handler(return_from_handler), .sleeping(sleeping),
    .irq_req(irq_req), .wake_req(wake_req), .force_nop(force_nop),
    .push_return(push_return), .pc_load(pc_load),
    .vector_addr(vector_addr), .q_phase(q_phase)
);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "mil_regs.vh"
`define CHK(n, e, s) begin n_compared = n_compared + 1; \
    if ((s) !== (e)) begin failures = failures + 1; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
// ==========================================================
// Top bench
module testbench;
    localparam [7:0] A_CTL = `MIL_OFF_CTRL;
    localparam [7:0] A_PFL = `MIL_OFF_PFLAGS;
    localparam [7:0] A_PEN = `MIL_OFF_PENABLES;
    localparam [7:0] A_OPT = `MIL_OFF_OPTION;
    reg         clock = 1'b0;
    reg         rst = 1'b1;
    reg  [7:0]  addr = 8'h00;
    reg  [7:0]  wdata = 8'h00;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg         pin = 1'b0;
    reg  [3:0]  port_pins = 4'h0;
    reg  [2:0]  ev = 3'h0;
    reg         sleeping = 1'b0;
    wire [7:0]  rdata;
    wire        irq_req, wake_req, force_nop, push_return, pc_load, ret;
    wire [12:0] vector_addr, pc;
    wire [1:0]  q_phase;
    integer     failures = 0;
    integer     n_compared = 0;
    integer     i;
    reg         sel;
    mil_irq dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .external_irq_pin(pin),
        .port_pins(port_pins), .port_read(ev[2]), .timer_rollover(ev[0]),
        .comparator_event(ev[1]), .return_from_handler(ret),
        .sleeping(sleeping), .irq_req(irq_req), .wake_req(wake_req),
        .force_nop(force_nop), .push_return(push_return),
        .pc_load(pc_load), .vector_addr(vector_addr), .q_phase(q_phase));
    mil_cpu_model cpu (.clock(clock), .rst(rst), .pc_load(pc_load),
        .vector_addr(vector_addr), .return_from_handler(ret), .pc(pc));
    initial begin
        forever #5 clock = ~clock;
    end
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
        begin
            @(posedge clock);
            addr <= a;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            #1;
            `CHK("rdata", e, rdata)
        end
    endtask
    task pulse(input [2:0] k);
        begin
            @(posedge clock);
            ev <= k;
            @(posedge clock);
            ev <= 3'h0;
        end
    endtask
    task wait_pc(input integer max);
        begin
            for (i = 0; i < max && pc_load !== 1'b1; i = i + 1)
                @(posedge clock) #1;
            `CHK("pc_load", 1'b1, pc_load)
        end
    endtask
    // Handler: flags must go before the return re-arms the global enable
    task serve(input [7:0] a, input [7:0] d, input [7:0] ectl);
        begin
            rd_chk(A_CTL, ectl);
            wr_reg(a, d);
            repeat (16) @(posedge clock);
            `CHK("pc", `MIL_VECTOR, pc)
        end
    endtask
    task t_reset;
        begin
            rd_chk(A_CTL, 8'h00);
            rd_chk(A_PFL, 8'h00);
            rd_chk(A_PEN, 8'h00);
            rd_chk(A_OPT, 8'h40);
            rd_chk(8'h00, 8'h00);
            $display("reset test done");
        end
    endtask
    task t_timer;
        begin
            wr_reg(A_CTL, 8'h20);
            pulse(3'h1);
            rd_chk(A_CTL, 8'h24);
            `CHK("irq_req", 1'b0, irq_req)
            wr_reg(A_CTL, 8'hA4);
            wait_pc(24);
            serve(A_CTL, 8'h20, 8'h24);
            rd_chk(A_CTL, 8'hA0);
            wr_reg(A_CTL, 8'h00);
            $display("timer test done");
        end
    endtask
    task t_pin;
        begin
            for (sel = 1'b1; 1; sel = 1'b0) begin
                @(posedge clock) pin <= ~sel;
                wr_reg(A_OPT, sel ? 8'h40 : 8'h00);
                repeat (6) @(posedge clock);
                wr_reg(A_CTL, 8'h00);
                @(posedge clock) pin <= sel;
                repeat (8) @(posedge clock);
                rd_chk(A_CTL, 8'h02);
                wr_reg(A_CTL, 8'h00);
                @(posedge clock) pin <= ~sel;
                repeat (8) @(posedge clock);
                rd_chk(A_CTL, 8'h00);
                if (!sel) break;
            end
            $display("pin edge test done");
        end
    endtask
    task t_wake;
        begin
            wr_reg(A_CTL, 8'h10);
            @(posedge clock) sleeping <= 1'b1;
            @(posedge clock) pin <= 1'b0;
            for (i = 0; i < 12 && wake_req !== 1'b1; i = i + 1)
                @(posedge clock) #1;
            `CHK("wake_req", 1'b1, wake_req)
            `CHK("irq_req", 1'b0, irq_req)
            @(posedge clock) sleeping <= 1'b0;
            wr_reg(A_CTL, 8'h10);
            @(posedge clock) pin <= 1'b1;
            repeat (8) @(posedge clock);
            wr_reg(A_CTL, 8'h90);
            @(posedge clock) pin <= 1'b0;
            wait_pc(24);
            serve(A_CTL, 8'h10, 8'h12);
            rd_chk(A_CTL, 8'h90);
            wr_reg(A_CTL, 8'h00);
            $display("wake test done");
        end
    endtask
    task t_port;
        begin
            wr_reg(A_CTL, 8'h08);
            pulse(3'h4);
            @(posedge clock) port_pins <= 4'hA;
            repeat (6) @(posedge clock);
            rd_chk(A_CTL, 8'h09);
            pulse(3'h4);
            wr_reg(A_CTL, 8'h08);
            rd_chk(A_CTL, 8'h08);
            $display("port test done");
        end
    endtask
    task t_cmp;
        begin
            wr_reg(A_PEN, 8'h40);
            rd_chk(A_PEN, 8'h40);
            pulse(3'h2);
            rd_chk(A_PFL, 8'h40);
            wr_reg(A_CTL, 8'h80);
            repeat (2) @(posedge clock);
            `CHK("irq_req", 1'b0, irq_req)
            wr_reg(A_CTL, 8'hC0);
            wait_pc(24);
            serve(A_PFL, 8'h00, 8'h40);
            rd_chk(A_CTL, 8'hC0);
            wr_reg(A_CTL, 8'h80);
            wr_reg(A_CTL, 8'h00);
            // The no-op flag rises one edge after the write lands
            @(posedge clock) #1;
            `CHK("force_nop", 1'b1, force_nop)
            repeat (8) @(posedge clock);
            $display("comparator and nop test done");
        end
    endtask
    task results;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        // Whole run is a few hundred cycles; this bound is generous
        #60000;
        failures = failures + 1;
        results;
    end
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_timer;
        t_pin;
        t_wake;
        t_port;
        t_cmp;
        results;
    end
endmodule
